// File: rss_pkg.sv
// package of the reset source sequencer: register map, reset values, timing counts, bus carriers
// assumes a single 50 MHz core clock and an axi4-lite master with 32-bit data
package rss_pkg;

  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned SETTLE_MS = 15;
  localparam int unsigned SETTLE_CYCLES = (SETTLE_MS * (CLK_HZ / 1000));
  localparam int unsigned DROOP_HOLD_US = 500;
  localparam int unsigned DROOP_HOLD_CYCLES = DROOP_HOLD_US * (CLK_HZ / 1_000_000);
  localparam int unsigned INT_RESET_CYCLES = 16;

  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_CAUSE = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_DROOP = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_REG = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_SRST0 = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_WDT_LOAD = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_WDT_CTRL = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_WDT_STAT = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_WDT_CNT = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h28;

  // cause record bit positions
  localparam int CB_EXT = 0;
  localparam int CB_POR = 1;
  localparam int CB_DROOP = 2;
  localparam int CB_SW = 3;
  localparam int CB_WDT = 4;
  localparam int CB_REG = 5;
  localparam int NUM_CAUSES = 6;
  localparam logic [NUM_CAUSES-1:0] CAUSE_RST = 6'h02;

  // droop_reset_control fields
  localparam int DB_DETECT_EN = 0;
  localparam int DB_RESET_EN = 1;
  localparam int DB_RECHECK_EN = 2;
  localparam int DB_DELAY_LSB = 8;
  localparam int DELAY_W = 8;
  localparam int DB_EVENT = 16;
  localparam logic [DELAY_W-1:0] DELAY_RST = 8'h00;

  // watchdog control fields
  localparam int WB_ENABLE = 0;
  localparam int WB_RESET_EN = 1;
  localparam logic [31:0] WDT_LOAD_RST = 32'hffffffff;

  localparam int NUM_SRST = 3;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [6:0] {
    ST_HOLD = 7'b0000001,
    ST_SETTLE = 7'b0000010,
    ST_INTRST = 7'b0000100,
    ST_FETCH_SP = 7'b0001000,
    ST_FETCH_PC = 7'b0010000,
    ST_FETCH_IN = 7'b0100000,
    ST_RUN = 7'b1000000
  } rss_state_t;

  typedef enum logic [1:0] {
    FK_SP = 2'b00,
    FK_PC = 2'b01,
    FK_INSTR = 2'b10
  } rss_fetch_t;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } rss_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rss_axi_rsp_t;

endpackage

// File: rss_top.sv
// reset source sequencer: gathers reset sources, sequences internal reset, records the cause
// assumes all inputs synchronous to core_clk; reset_n is the very first power-up of this logic
//
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
module rss_top
  import rss_pkg::*;
#(
  parameter int unsigned SETTLE_COUNT = rss_pkg::SETTLE_CYCLES,
  parameter int unsigned DROOP_HOLD_COUNT = rss_pkg::DROOP_HOLD_CYCLES,
  parameter int unsigned INT_RESET_COUNT = rss_pkg::INT_RESET_CYCLES,
  parameter int NUM_PERIPH = 32 * rss_pkg::NUM_SRST
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // register bus
  input rss_pkg::rss_axi_req_t axi_req,
  output rss_pkg::rss_axi_rsp_t axi_rsp,
  // reset sources
  input wire logic ext_reset_pin_n,
  input wire logic por_active,
  input wire logic droop_detect,
  input wire logic regulator_unreg,
  input wire logic system_reset_request,
  // core boot fetch handshake
  output logic fetch_req,
  output rss_pkg::rss_fetch_t fetch_kind,
  input wire logic fetch_ack,
  // reset outputs
  output logic core_reset_n,
  output logic periph_reset_n,
  output logic tap_reset_n,
  output logic [NUM_PERIPH-1:0] periph_soft_reset_main,
  output logic [NUM_PERIPH-1:0] periph_soft_reset_aux,
  output logic droop_signal_hold,
  // events to the core
  output logic droop_irq,
  output logic wdt_irq
);
  import rss_pkg::*;

  rss_state_t state_r, state_nxt;
  logic [31:0] seq_cnt_r;
  logic [NUM_CAUSES-1:0] cause_r, cause_nxt;
  logic droop_detect_en_r, droop_reset_en_r, droop_recheck_en_r, droop_event_r;
  logic [DELAY_W-1:0] droop_delay_r;
  logic regulator_fault_reset_r;
  logic [31:0] srst_r [NUM_SRST];
  logic [31:0] wdt_load_r, wdt_cnt_r;
  logic wdt_enable_r, wdt_reset_en_r, wdt_int_r;
  logic [DELAY_W-1:0] recheck_cnt_r;
  logic recheck_busy_r;
  logic [31:0] droop_hold_cnt_r;
  logic ev_ext, ev_por, ev_droop, ev_sw, ev_wdt, ev_reg, ev_internal, droop_confirm;
  logic wdt_timeout, wdt_load_wr;

  // bus slave state
  logic aw_held_r, w_held_r, bvalid_r, rvalid_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r, rdata_r;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r, rresp_r;
  logic wr_fire;
  logic [31:0] rd_val;
  logic rd_hit;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return (a[1:0] == 2'b00) && (a <= OFS_STATUS);
  endfunction

  // write channels taken in either order; response once both are held
  assign wr_fire = aw_held_r && w_held_r && !bvalid_r;

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end
    else
    begin
      if (axi_req.awvalid && !aw_held_r)
      begin
        aw_held_r <= 1'b1;
        awaddr_r <= axi_req.awaddr;
      end
      else if (wr_fire)
      begin
        aw_held_r <= 1'b0;
      end
      if (axi_req.wvalid && !w_held_r)
      begin
        w_held_r <= 1'b1;
        wdata_r <= axi_req.wdata;
        wstrb_r <= axi_req.wstrb;
      end
      else if (wr_fire)
      begin
        w_held_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_r <= 1'b1;
      bresp_r <= mapped(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (axi_req.bready)
    begin
      bvalid_r <= 1'b0;
    end
  end

  always_comb
  begin
    rd_val = 32'h00000000;
    rd_hit = mapped(axi_req.araddr);
    unique case (axi_req.araddr)
      OFS_CAUSE: rd_val[NUM_CAUSES-1:0] = cause_r;
      OFS_DROOP:
      begin
        rd_val[DB_DETECT_EN] = droop_detect_en_r;
        rd_val[DB_RESET_EN] = droop_reset_en_r;
        rd_val[DB_RECHECK_EN] = droop_recheck_en_r;
        rd_val[DB_DELAY_LSB +: DELAY_W] = droop_delay_r;
        rd_val[DB_EVENT] = droop_event_r;
      end
      OFS_REG: rd_val[0] = regulator_fault_reset_r;
      OFS_SRST0: rd_val = srst_r[0];
      OFS_SRST0 + 8'h04: rd_val = srst_r[1];
      OFS_SRST0 + 8'h08: rd_val = srst_r[2];
      OFS_WDT_LOAD: rd_val = wdt_load_r;
      OFS_WDT_CTRL: rd_val[1:0] = {wdt_reset_en_r, wdt_enable_r};
      OFS_WDT_STAT: rd_val[0] = wdt_int_r;
      OFS_WDT_CNT: rd_val = wdt_cnt_r;
      OFS_STATUS: rd_val[6:0] = state_r;
      default: rd_val = 32'h00000000;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end
    else if (axi_req.arvalid && !rvalid_r)
    begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_val;
      rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (axi_req.rready)
    begin
      rvalid_r <= 1'b0;
    end
  end

  assign axi_rsp.awready = !aw_held_r;
  assign axi_rsp.wready = !w_held_r;
  assign axi_rsp.bvalid = bvalid_r;
  assign axi_rsp.bresp = bresp_r;
  assign axi_rsp.arready = !rvalid_r;
  assign axi_rsp.rvalid = rvalid_r;
  assign axi_rsp.rdata = rdata_r;
  assign axi_rsp.rresp = rresp_r;

  // control registers; these survive internal resets, only reset_n clears them
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      droop_detect_en_r <= 1'b0;
      droop_reset_en_r <= 1'b0;
      droop_recheck_en_r <= 1'b0;
      droop_delay_r <= DELAY_RST;
      regulator_fault_reset_r <= 1'b0;
      wdt_load_r <= WDT_LOAD_RST;
      wdt_enable_r <= 1'b0;
      wdt_reset_en_r <= 1'b0;
    end
    else if (wr_fire)
    begin
      unique case (awaddr_r)
        OFS_DROOP:
        begin
          if (wstrb_r[0])
          begin
            droop_detect_en_r <= wdata_r[DB_DETECT_EN];
            droop_reset_en_r <= wdata_r[DB_RESET_EN];
            droop_recheck_en_r <= wdata_r[DB_RECHECK_EN];
          end
          if (wstrb_r[1])
          begin
            droop_delay_r <= wdata_r[DB_DELAY_LSB +: DELAY_W];
          end
        end
        OFS_REG:
        begin
          if (wstrb_r[0])
          begin
            regulator_fault_reset_r <= wdata_r[0];
          end
        end
        OFS_WDT_LOAD: wdt_load_r <= merge(wdt_load_r, wdata_r, wstrb_r);
        OFS_WDT_CTRL:
        begin
          if (wstrb_r[0])
          begin
            wdt_enable_r <= wdata_r[WB_ENABLE];
            wdt_reset_en_r <= wdata_r[WB_RESET_EN];
          end
        end
        default:
        begin
        end
      endcase
    end
  end

  // peripheral soft resets: a set bit holds its unit in reset until written back to 0
  generate
    for (genvar g = 0; g < NUM_SRST; g++)
    begin : g_srst
      always_ff @(posedge core_clk)
      begin
        if (!reset_n)
        begin
          srst_r[g] <= 32'h00000000;
        end
        else if (wr_fire && awaddr_r == OFS_SRST0 + ADDR_W'(4 * g))
        begin
          srst_r[g] <= merge(srst_r[g], wdata_r, wstrb_r);
        end
      end
      // both domains of every unit see the same request
      always_ff @(posedge core_clk)
      begin
        if (!reset_n)
        begin
          periph_soft_reset_main[g*32 +: 32] <= 32'h00000000;
          periph_soft_reset_aux[g*32 +: 32] <= 32'h00000000;
        end
        else
        begin
          periph_soft_reset_main[g*32 +: 32] <= srst_r[g];
          periph_soft_reset_aux[g*32 +: 32] <= srst_r[g];
        end
      end
    end
  endgenerate

  // reset source events
  assign ev_ext = !ext_reset_pin_n;
  assign ev_por = por_active;
  assign ev_sw = system_reset_request;
  assign ev_reg = regulator_unreg && regulator_fault_reset_r;
  assign ev_droop = droop_confirm && droop_reset_en_r;
  assign ev_wdt = wdt_timeout && wdt_int_r && wdt_reset_en_r;
  assign ev_internal = ev_sw || ev_reg || ev_droop || ev_wdt;

  // droop recheck: a new condition is ignored while a recheck runs or the hold is active
  assign droop_confirm = droop_detect && droop_detect_en_r && !droop_signal_hold &&
                         (recheck_busy_r ? (recheck_cnt_r == '0) : !droop_recheck_en_r);

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      recheck_busy_r <= 1'b0;
      recheck_cnt_r <= '0;
    end
    else if (recheck_busy_r)
    begin
      if (recheck_cnt_r == '0)
      begin
        recheck_busy_r <= 1'b0;
      end
      else
      begin
        recheck_cnt_r <= recheck_cnt_r - 1'b1;
      end
    end
    else if (droop_detect && droop_detect_en_r && droop_recheck_en_r && !droop_signal_hold)
    begin
      recheck_busy_r <= 1'b1;
      recheck_cnt_r <= droop_delay_r;
    end
  end

  // hold the internal droop signal after a droop reset so no new condition is latched
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      droop_signal_hold <= 1'b0;
      droop_hold_cnt_r <= '0;
    end
    else if (ev_droop)
    begin
      droop_signal_hold <= 1'b1;
      droop_hold_cnt_r <= DROOP_HOLD_COUNT - 1;
    end
    else if (droop_signal_hold)
    begin
      if (droop_hold_cnt_r == '0)
      begin
        droop_signal_hold <= 1'b0;
      end
      else
      begin
        droop_hold_cnt_r <= droop_hold_cnt_r - 32'h00000001;
      end
    end
  end

  // droop interrupt flag: set wins over a write-one clear
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      droop_event_r <= 1'b0;
    end
    else if (droop_confirm && !droop_reset_en_r)
    begin
      droop_event_r <= 1'b1;
    end
    else if (wr_fire && awaddr_r == OFS_DROOP && wstrb_r[2] && wdata_r[DB_EVENT])
    begin
      droop_event_r <= 1'b0;
    end
  end
  assign droop_irq = droop_event_r;

  // watchdog: first zero raises the interrupt and reloads, second zero may reset
  assign wdt_timeout = wdt_enable_r && (wdt_cnt_r == 32'h00000000);
  assign wdt_load_wr = wr_fire && awaddr_r == OFS_WDT_LOAD;

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      wdt_cnt_r <= WDT_LOAD_RST;
    end
    else if (wdt_load_wr || wdt_timeout)
    begin
      wdt_cnt_r <= wdt_load_wr ? merge(wdt_load_r, wdata_r, wstrb_r) : wdt_load_r;
    end
    else if (wdt_enable_r)
    begin
      wdt_cnt_r <= wdt_cnt_r - 32'h00000001;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      wdt_int_r <= 1'b0;
    end
    else if (wdt_timeout)
    begin
      wdt_int_r <= 1'b1;
    end
    else if (wr_fire && awaddr_r == OFS_WDT_STAT && wstrb_r[0] && wdata_r[0])
    begin
      wdt_int_r <= 1'b0;
    end
  end
  assign wdt_irq = wdt_int_r;

  // cause record: hardware sets win over software clears
  always_comb
  begin
    cause_nxt = cause_r;
    if (wr_fire && awaddr_r == OFS_CAUSE && wstrb_r[0])
    begin
      cause_nxt = cause_r & ~wdata_r[NUM_CAUSES-1:0];
    end
    cause_nxt[CB_POR] = cause_nxt[CB_POR] | ev_por;
    cause_nxt[CB_DROOP] = cause_nxt[CB_DROOP] | ev_droop;
    cause_nxt[CB_SW] = cause_nxt[CB_SW] | ev_sw;
    cause_nxt[CB_WDT] = cause_nxt[CB_WDT] | ev_wdt;
    cause_nxt[CB_REG] = cause_nxt[CB_REG] | ev_reg;
    if (ev_ext)
    begin
      cause_nxt = '0;
      cause_nxt[CB_EXT] = 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      cause_r <= CAUSE_RST;
    end
    else
    begin
      cause_r <= cause_nxt;
    end
  end

  // sequencer; one clock stands in for both oscillators, the counts differ per path
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_HOLD:
      begin
        if (!ev_ext && !ev_por)
        begin
          state_nxt = ST_SETTLE;
        end
      end
      ST_SETTLE:
      begin
        if (seq_cnt_r == '0)
        begin
          state_nxt = ST_FETCH_SP;
        end
      end
      ST_INTRST:
      begin
        if (seq_cnt_r == '0)
        begin
          state_nxt = ST_FETCH_SP;
        end
      end
      ST_FETCH_SP: state_nxt = fetch_ack ? ST_FETCH_PC : ST_FETCH_SP;
      ST_FETCH_PC: state_nxt = fetch_ack ? ST_FETCH_IN : ST_FETCH_PC;
      ST_FETCH_IN: state_nxt = fetch_ack ? ST_RUN : ST_FETCH_IN;
      ST_RUN: state_nxt = ST_RUN;
      default: state_nxt = ST_HOLD;
    endcase
    if (ev_ext || ev_por)
    begin
      state_nxt = ST_HOLD;
    end
    else if (ev_internal && state_r != ST_HOLD && state_r != ST_SETTLE)
    begin
      state_nxt = ST_INTRST;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      state_r <= ST_HOLD;
      seq_cnt_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      if (state_nxt == ST_SETTLE && state_r != ST_SETTLE)
      begin
        seq_cnt_r <= SETTLE_COUNT - 1;
      end
      else if (state_nxt == ST_INTRST && (state_r != ST_INTRST || ev_internal))
      begin
        seq_cnt_r <= INT_RESET_COUNT - 1;
      end
      else if (seq_cnt_r != '0)
      begin
        seq_cnt_r <= seq_cnt_r - 32'h00000001;
      end
    end
  end

  // reset outputs come straight from flops so core and peripherals leave reset on one edge; tap_reset_n follows por_active alone
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      core_reset_n <= 1'b0;
      periph_reset_n <= 1'b0;
      tap_reset_n <= 1'b0;
    end
    else
    begin
      core_reset_n <= !(state_nxt inside {ST_HOLD, ST_SETTLE, ST_INTRST});
      periph_reset_n <= !(state_nxt inside {ST_HOLD, ST_SETTLE, ST_INTRST});
      tap_reset_n <= !ev_por;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      fetch_req <= 1'b0;
      fetch_kind <= FK_SP;
    end
    else
    begin
      fetch_req <= state_nxt inside {ST_FETCH_SP, ST_FETCH_PC, ST_FETCH_IN};
      fetch_kind <= (state_nxt == ST_FETCH_PC) ? FK_PC :
                    (state_nxt == ST_FETCH_IN) ? FK_INSTR : FK_SP;
    end
  end

endmodule

// File: rss_core_model.sv
// core side model: answers each boot fetch after a settable wait
// assumes fetch_req and fetch_kind registered on core_clk
module rss_core_model
  import rss_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // boot fetch
  input wire logic fetch_req,
  input rss_pkg::rss_fetch_t fetch_kind,
  input wire logic [3:0] ack_delay,
  output logic fetch_ack,
  output logic [7:0] n_acks
);
  logic [3:0] wait_r;
  // the wait restarts after every ack, so the new kind has settled first
  always_ff @(posedge core_clk)
  begin
    if (!reset_n || !fetch_req || fetch_ack)
    begin
      fetch_ack <= 1'b0;
      wait_r <= 4'h0;
    end
    else if (wait_r >= ack_delay)
      fetch_ack <= 1'b1;
    else
      wait_r <= wait_r + 4'h1;
  end
  always_ff @(posedge core_clk)
    n_acks <= !reset_n ? 8'h00 : n_acks + 8'(fetch_req && fetch_ack);
endmodule

// File: rss_monitor.sv
// port checker of the reset source sequencer
// assumes the count parameters of the bound instance are handed on
module rss_monitor
  import rss_pkg::*;
#(
  parameter int unsigned SETTLE_COUNT = rss_pkg::SETTLE_CYCLES,
  parameter int unsigned DROOP_HOLD_COUNT = rss_pkg::DROOP_HOLD_CYCLES,
  parameter int NUM_PERIPH = 96
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // sources
  input wire logic ext_reset_pin_n,
  input wire logic por_active,
  input wire logic system_reset_request,
  // boot fetch
  input wire logic fetch_req,
  input rss_pkg::rss_fetch_t fetch_kind,
  input wire logic fetch_ack,
  // reset outputs
  input wire logic core_reset_n,
  input wire logic periph_reset_n,
  input wire logic tap_reset_n,
  input wire logic [NUM_PERIPH-1:0] periph_soft_reset_main,
  input wire logic [NUM_PERIPH-1:0] periph_soft_reset_aux,
  input wire logic droop_signal_hold
);
  logic [31:0] quiet_r;
  logic [31:0] hold_r;
  logic pend_r;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // cycles since the pin or power-on detector was last active
  always_ff @(posedge core_clk)
    quiet_r <= (!reset_n || !ext_reset_pin_n || por_active) ? 32'h0 : quiet_r + 32'h1;
  always_ff @(posedge core_clk)
    pend_r <= !reset_n || !ext_reset_pin_n || por_active || (pend_r && !core_reset_n);
  always_ff @(posedge core_clk)
    hold_r <= droop_signal_hold ? hold_r + 32'h1 : 32'h0;
  property p_tap;
    $past(reset_n) && !$past(por_active) |-> tap_reset_n;
  endproperty
  a_tap: assert property (p_tap) else $error("tap reset");
  property p_pin;
    !ext_reset_pin_n |-> ##[1:2] (!core_reset_n && !periph_reset_n);
  endproperty
  a_pin: assert property (p_pin) else $error("pin reset");
  property p_settle_min;
    pend_r && core_reset_n |-> quiet_r >= SETTLE_COUNT;
  endproperty
  a_settle_min: assert property (p_settle_min) else $error("settle short");
  property p_settle_max;
    pend_r && quiet_r > 2 * SETTLE_COUNT + 2 |-> core_reset_n;
  endproperty
  a_settle_max: assert property (p_settle_max) else $error("settle long");
  property p_fetch_first;
    $rose(fetch_req) |-> fetch_kind == FK_SP && core_reset_n && periph_reset_n;
  endproperty
  a_fetch_first: assert property (p_fetch_first) else $error("fetch start");
  property p_fetch_next;
    fetch_req && fetch_ack && fetch_kind != FK_INSTR |=>
      fetch_req && fetch_kind == $past(fetch_kind) + 2'b01;
  endproperty
  a_fetch_next: assert property (p_fetch_next) else $error("fetch order");
  property p_domains;
    periph_soft_reset_main == periph_soft_reset_aux;
  endproperty
  a_domains: assert property (p_domains) else $error("soft domains");
  property p_droop_hold;
    $fell(droop_signal_hold) |-> hold_r >= DROOP_HOLD_COUNT;
  endproperty
  a_droop_hold: assert property (p_droop_hold) else $error("droop hold");
  property p_sysreq;
    core_reset_n && !fetch_req && system_reset_request |-> ##[1:2] !core_reset_n;
  endproperty
  a_sysreq: assert property (p_sysreq) else $error("system request");
  c_boot: cover property ($rose(fetch_req));
  c_hold: cover property ($fell(droop_signal_hold));
  c_pin: cover property ($rose(ext_reset_pin_n));
endmodule
bind rss_top rss_monitor #(.SETTLE_COUNT(SETTLE_COUNT), .DROOP_HOLD_COUNT(DROOP_HOLD_COUNT),
  .NUM_PERIPH(NUM_PERIPH)) mon (.core_clk, .reset_n, .ext_reset_pin_n, .por_active,
  .system_reset_request, .fetch_req, .fetch_kind, .fetch_ack, .core_reset_n, .periph_reset_n,
  .tap_reset_n, .periph_soft_reset_main, .periph_soft_reset_aux, .droop_signal_hold);

// File: tb_top.sv
// bench of the reset source sequencer: bus tasks and source stimulus
// assumes shortened counts and the core model answering boot fetches
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rss_pkg::*;
  localparam int unsigned SC = 40;
  localparam int unsigned DH = 60;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic pin_n = 1'b1;
  logic por = 1'b1;
  logic droop = 1'b0;
  logic unreg = 1'b0;
  logic sysreq = 1'b0;
  logic [3:0] ack_delay = 4'h0;
  rss_axi_req_t axi_req = '0;
  rss_axi_rsp_t axi_rsp;
  rss_fetch_t fetch_kind;
  logic fetch_req, fetch_ack, core_reset_n, periph_reset_n, tap_reset_n, hold, d_irq, w_irq;
  logic [95:0] sr_main, sr_aux;
  logic [7:0] n_acks;
  logic [31:0] q;
  logic [1:0] resp;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc, i, a0, k;
  always #10 core_clk = ~core_clk;
  rss_top #(.SETTLE_COUNT(SC), .DROOP_HOLD_COUNT(DH), .INT_RESET_COUNT(4)) uut (.core_clk,
    .reset_n, .axi_req, .axi_rsp, .ext_reset_pin_n(pin_n), .por_active(por),
    .droop_detect(droop), .regulator_unreg(unreg), .system_reset_request(sysreq), .fetch_req,
    .fetch_kind, .fetch_ack, .core_reset_n, .periph_reset_n, .tap_reset_n,
    .periph_soft_reset_main(sr_main), .periph_soft_reset_aux(sr_aux),
    .droop_signal_hold(hold), .droop_irq(d_irq), .wdt_irq(w_irq));
  rss_core_model core (.core_clk, .reset_n, .fetch_req, .fetch_kind, .ack_delay, .fetch_ack,
    .n_acks);
  task automatic test_done();
    if (n_mismatch == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic fail();
    n_mismatch++;
    test_done();
  endtask
  task automatic chk(input string nm, input logic [95:0] seen, input logic [95:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic clk(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // one transfer; each valid held to its own handshake; bready/rready stay up until the next call
  task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d);
    bit done;
    int t;
    done = 1'b0;
    axi_req.awaddr <= a;
    axi_req.araddr <= a;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hf;
    axi_req.awvalid <= w;
    axi_req.wvalid <= w;
    axi_req.bready <= w;
    axi_req.arvalid <= !w;
    axi_req.rready <= !w;
    for (t = 0; t < 100 && !done; t++)
    begin
      @(posedge core_clk);
      if (axi_req.awvalid && axi_rsp.awready)
        axi_req.awvalid <= 1'b0;
      if (axi_req.wvalid && axi_rsp.wready)
        axi_req.wvalid <= 1'b0;
      if (axi_req.arvalid && axi_rsp.arready)
        axi_req.arvalid <= 1'b0;
      if ((axi_req.bready && axi_rsp.bvalid) || (axi_req.rready && axi_rsp.rvalid))
      begin
        done = 1'b1;
        q = axi_rsp.rdata;
        resp = w ? axi_rsp.bresp : axi_rsp.rresp;
      end
    end
    if (!done)
      fail();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(nm, q, exp);
  endtask
  // waits for core reset to fall, then counts cycles until boot is over
  task automatic reboot();
    a0 = n_acks;
    for (i = 0; i < 300 && core_reset_n !== 1'b0; i++)
      @(posedge core_clk);
    for (cyc = 0; cyc < 300 && !(core_reset_n === 1'b1 && fetch_req === 1'b0); cyc++)
      @(posedge core_clk);
    if (i == 300 || cyc == 300)
      fail();
    chk("fetches", 8'(n_acks - a0), 8'h03);
  endtask
  task automatic pulse(input int n);
    droop <= 1'b1;
    clk(n);
    droop <= 1'b0;
    clk(12);
  endtask
  initial
  begin
    clk(16);
    reset_n <= 1'b1;
    clk(3);
    // pin stays released here: a low pin would clear the power-on cause bit
    por <= 1'b0;
    reboot();
    chk("tap", tap_reset_n, 1'b1);
    chk("power settle", cyc >= SC && cyc <= 2 * SC + 12, 1'b1);
    rd("cause", OFS_CAUSE, 32'h02);
    rd("droop ctl", OFS_DROOP, 32'h0);
    rd("reg ctl", OFS_REG, 32'h0);
    rd("reload", OFS_WDT_LOAD, WDT_LOAD_RST);
    rd("state", OFS_STATUS, 32'h40);
    bus(1'b0, 8'h2c, 32'h0);
    chk("unmapped", resp, RESP_SLVERR);
    pulse(4);
    chk("droop off", {d_irq, core_reset_n}, 2'b01);
    wr(OFS_DROOP, 32'h1);
    pulse(3);
    chk("droop irq", {d_irq, core_reset_n}, 2'b11);
    wr(OFS_DROOP, 32'h10507);
    pulse(1);
    chk("noise", {d_irq, core_reset_n}, 2'b01);
    wr(OFS_CAUSE, 32'h3f);
    // resample lands on the 7th edge; stop before the short internal reset ends
    droop <= 1'b1;
    clk(8);
    droop <= 1'b0;
    reboot();
    chk("hold on", hold, 1'b1);
    chk("internal short", cyc < SC, 1'b1);
    rd("cause", OFS_CAUSE, 32'h04);
    clk(DH);
    chk("hold off", hold, 1'b0);
    wr(OFS_DROOP, 32'h0);
    sysreq <= 1'b1;
    clk(1);
    sysreq <= 1'b0;
    reboot();
    rd("cause", OFS_CAUSE, 32'h0c);
    ack_delay <= 4'h3;
    unreg <= 1'b1;
    clk(6);
    chk("reg off", core_reset_n, 1'b1);
    wr(OFS_REG, 32'h1);
    clk(2);
    unreg <= 1'b0;
    reboot();
    rd("cause", OFS_CAUSE, 32'h2c);
    wr(OFS_REG, 32'h0);
    wr(OFS_WDT_LOAD, 32'd60);
    wr(OFS_WDT_CTRL, 32'h3);
    for (k = 0; k < 200 && w_irq !== 1'b1; k++)
      clk(1);
    chk("wdt first", {w_irq, core_reset_n}, 2'b11);
    bus(1'b0, OFS_WDT_CNT, 32'h0);
    chk("reloaded", q > 32'd40 && q <= 32'd60, 1'b1);
    wr(OFS_WDT_STAT, 32'h1);
    chk("irq clear", w_irq, 1'b0);
    for (k = 0; k < 200 && w_irq !== 1'b1; k++)
      clk(1);
    chk("wdt cleared", {w_irq, core_reset_n}, 2'b11);
    reboot();
    rd("cause", OFS_CAUSE, 32'h3c);
    wr(OFS_WDT_CTRL, 32'h0);
    wr(OFS_WDT_STAT, 32'h1);
    for (k = 0; k < 3; k++)
    begin
      wr(OFS_SRST0 + 8'(4 * k), 32'h00010001 << k);
      clk(1);
      chk("soft main", sr_main, 96'h10001 << (33 * k));
      chk("soft aux", sr_aux, 96'h10001 << (33 * k));
      wr(OFS_SRST0 + 8'(4 * k), 32'h0);
    end
    clk(1);
    chk("soft off", sr_main | sr_aux, 96'h0);
    pin_n <= 1'b0;
    clk(4);
    chk("pin", {core_reset_n, periph_reset_n, tap_reset_n}, 3'b001);
    pin_n <= 1'b1;
    reboot();
    chk("pin settle", cyc >= SC && cyc <= 2 * SC + 20, 1'b1);
    rd("cause", OFS_CAUSE, 32'h01);
    test_done();
  end
endmodule
